// ### rtl/ssioc_cfg.svh
// Constants for the SRAM scan instruction and output control block.
`ifndef SSIOC_CFG_SVH
`define SSIOC_CFG_SVH
`define SSIOC_IR_W      3
`define SSIOC_I_EXTEST  3'h0
`define SSIOC_I_IDREAD  3'h1
`define SSIOC_I_SAMPZ   3'h2
`define SSIOC_I_SAMPLE  3'h4
`define SSIOC_I_BYPASS  3'h7
`define SSIOC_IR_CAPT   3'h1
`define SSIOC_DATA_W    36
`define SSIOC_IN_W      71
`define SSIOC_ID_W      32
`endif

// ### rtl/ssioc_pkg.sv
// Types shared by the scan instruction and output control block.
package ssioc_pkg;
`include "ssioc_cfg.svh"

    // One-hot test port controller states.
    typedef enum logic [15:0] {
        ST_TLR    = 16'h0001,
        ST_RTI    = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SH_DR  = 16'h0010,
        ST_EX1_DR = 16'h0020,
        ST_PAU_DR = 16'h0040,
        ST_EX2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SH_IR  = 16'h0800,
        ST_EX1_IR = 16'h1000,
        ST_PAU_IR = 16'h2000,
        ST_EX2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } ssioc_tap_st_t;

    // Source that drives one group of output pins.
    typedef enum logic [1:0] {
        PM_SRAM = 2'h0,
        PM_UPD  = 2'h1,
        PM_HIZ  = 2'h2
    } ssioc_pin_mode_t;

    typedef struct packed {
        ssioc_pin_mode_t echo;
        ssioc_pin_mode_t q;
    } ssioc_pin_sel_t;

    // Scan state that the core domain needs to steer the pins.
    typedef struct packed {
        logic [`SSIOC_IR_W-1:0] instr;
        logic                   ctrl;
    } ssioc_scan_ctl_t;
endpackage : ssioc_pkg

// ### rtl/ssioc_tap_fsm.sv
// Sixteen-state test port controller on the test clock.
`timescale 1ns/1ps
`default_nettype none
module ssioc_tap_fsm (
    input  wire logic                   test_clk,
    input  wire logic                   tap_rst,
    input  wire logic                   tms,
    output var  ssioc_pkg::ssioc_tap_st_t state_ff
);
    ssioc_pkg::ssioc_tap_st_t nxt_state;

    // Next state follows the mode-select level at each rising edge.
    always_comb
    begin
        case (state_ff)
            ssioc_pkg::ST_TLR:    nxt_state = tms ? ssioc_pkg::ST_TLR    : ssioc_pkg::ST_RTI;
            ssioc_pkg::ST_RTI:    nxt_state = tms ? ssioc_pkg::ST_SEL_DR : ssioc_pkg::ST_RTI;
            ssioc_pkg::ST_SEL_DR: nxt_state = tms ? ssioc_pkg::ST_SEL_IR : ssioc_pkg::ST_CAP_DR;
            ssioc_pkg::ST_CAP_DR: nxt_state = tms ? ssioc_pkg::ST_EX1_DR : ssioc_pkg::ST_SH_DR;
            ssioc_pkg::ST_SH_DR:  nxt_state = tms ? ssioc_pkg::ST_EX1_DR : ssioc_pkg::ST_SH_DR;
            ssioc_pkg::ST_EX1_DR: nxt_state = tms ? ssioc_pkg::ST_UPD_DR : ssioc_pkg::ST_PAU_DR;
            ssioc_pkg::ST_PAU_DR: nxt_state = tms ? ssioc_pkg::ST_EX2_DR : ssioc_pkg::ST_PAU_DR;
            ssioc_pkg::ST_EX2_DR: nxt_state = tms ? ssioc_pkg::ST_UPD_DR : ssioc_pkg::ST_SH_DR;
            ssioc_pkg::ST_UPD_DR: nxt_state = tms ? ssioc_pkg::ST_SEL_DR : ssioc_pkg::ST_RTI;
            ssioc_pkg::ST_SEL_IR: nxt_state = tms ? ssioc_pkg::ST_TLR    : ssioc_pkg::ST_CAP_IR;
            ssioc_pkg::ST_CAP_IR: nxt_state = tms ? ssioc_pkg::ST_EX1_IR : ssioc_pkg::ST_SH_IR;
            ssioc_pkg::ST_SH_IR:  nxt_state = tms ? ssioc_pkg::ST_EX1_IR : ssioc_pkg::ST_SH_IR;
            ssioc_pkg::ST_EX1_IR: nxt_state = tms ? ssioc_pkg::ST_UPD_IR : ssioc_pkg::ST_PAU_IR;
            ssioc_pkg::ST_PAU_IR: nxt_state = tms ? ssioc_pkg::ST_EX2_IR : ssioc_pkg::ST_PAU_IR;
            ssioc_pkg::ST_EX2_IR: nxt_state = tms ? ssioc_pkg::ST_UPD_IR : ssioc_pkg::ST_SH_IR;
            ssioc_pkg::ST_UPD_IR: nxt_state = tms ? ssioc_pkg::ST_SEL_DR : ssioc_pkg::ST_RTI;
            default:              nxt_state = ssioc_pkg::ST_TLR;
        endcase
    end

    // State register; reset parks the controller in test-logic-reset.
    always_ff @(posedge test_clk)
    begin
        if (tap_rst)
            state_ff <= ssioc_pkg::ST_TLR;
        else
            state_ff <= nxt_state;
    end

    sequence s_five_tms_hi;
        tms [*5];
    endsequence

    a_tms_reset_walk: assert property (@(posedge test_clk) disable iff (tap_rst)
        s_five_tms_hi |=> state_ff == ssioc_pkg::ST_TLR)
        else $error("Five high mode-select edges did not reach reset state.");

    a_ir_exit_update: assert property (@(posedge test_clk) disable iff (tap_rst)
        (state_ff == ssioc_pkg::ST_SH_IR && tms) ##1 tms |=> state_ff == ssioc_pkg::ST_UPD_IR)
        else $error("Instruction scan exit did not pass through update.");
endmodule : ssioc_tap_fsm
`default_nettype wire

// ### rtl/ssioc_top.sv
// Scan instruction decode, output pin control and capture source selection.
`timescale 1ns/1ps
`default_nettype none
`include "ssioc_cfg.svh"
// Function
// - Isolating sample floats all outputs, captures pads.
// - External test drives update; data needs control.
// - Other instructions pass the normal SRAM output.
// - Control bit loads at update under ext/sample.
// - External test and isolate capture pad levels.
// - Sample captures internal, idle data pads.
// - Idle test port leaves memory untouched.
// - Reset state and power-up select identification.
// - Sample capture loads input pins, then shifts.
module ssioc_top #(
    parameter int                     DATA_W  = `SSIOC_DATA_W,
    parameter int                     IN_W    = `SSIOC_IN_W,
    parameter logic [`SSIOC_ID_W-1:0] ID_CODE = 32'h0000_0001 // Arbitrary value.
) (
    input  wire logic              core_clk,
    input  wire logic              reset,
    input  wire logic              test_clk,
    input  wire logic              tms,
    input  wire logic              tdi,
    output logic                   tdo,
    output logic                   tdo_oe,
    input  wire logic [DATA_W-1:0] sram_q,
    input  wire logic              sram_q_oe,
    input  wire logic              sram_echo,
    input  wire logic              sram_echo_n,
    input  wire logic [IN_W-1:0]   pad_in,
    input  wire logic [DATA_W-1:0] pad_q_in,
    input  wire logic              pad_echo_in,
    input  wire logic              pad_echo_n_in,
    output logic                   echo_clock_out,
    output logic                   echo_clock_out_oe,
    output logic                   echo_clock_out_n,
    output logic                   echo_clock_out_n_oe,
    output logic [DATA_W-1:0]      rd_q_out,
    output logic [DATA_W-1:0]      rd_q_oe
);
    localparam int IR_W     = `SSIOC_IR_W;
    localparam int ID_W     = `SSIOC_ID_W;
    localparam int BSR_LEN  = IN_W + DATA_W + 3;
    localparam int Q_LO     = IN_W;
    localparam int CTRL_POS = BSR_LEN - 1;
    localparam int UPD_W    = DATA_W + 2;
    localparam int CORE_W   = DATA_W + 3;

    generate
        if (DATA_W < 1 || IN_W < 1)
        begin : g_bad_width
            $error("ssioc_top needs DATA_W and IN_W of at least one.");
        end
    endgenerate

    // Pin modes per instruction; reserved and unknown codes act as normal.
    function automatic ssioc_pkg::ssioc_pin_sel_t pin_mode(
        input logic [IR_W-1:0] instr,
        input logic            ctrl
    );
        ssioc_pkg::ssioc_pin_sel_t sel;
        sel.echo = ssioc_pkg::PM_SRAM;
        sel.q    = ssioc_pkg::PM_SRAM;
        case (instr)
            `SSIOC_I_EXTEST:
            begin
                sel.echo = ssioc_pkg::PM_UPD;
                sel.q    = ctrl ? ssioc_pkg::PM_UPD : ssioc_pkg::PM_HIZ;
            end
            `SSIOC_I_SAMPZ:
            begin
                sel.echo = ssioc_pkg::PM_HIZ;
                sel.q    = ssioc_pkg::PM_HIZ;
            end
            default: sel = sel;
        endcase
        return sel;
    endfunction : pin_mode

    // Instructions that place the boundary register in the scan path.
    function automatic logic uses_bsr(input logic [IR_W-1:0] instr);
        return instr == `SSIOC_I_EXTEST || instr == `SSIOC_I_SAMPZ ||
               instr == `SSIOC_I_SAMPLE;
    endfunction : uses_bsr

    // ---- Test clock domain ----
    logic                     rst_meta_ff;
    logic                     tap_rst_ff;
    logic [BSR_LEN-2:0]       pad_meta_ff;
    logic [BSR_LEN-2:0]       pad_s_ff;
    logic [CORE_W-1:0]        core_meta_ff;
    logic [CORE_W-1:0]        core_s_ff;
    ssioc_pkg::ssioc_tap_st_t tap_st;
    logic [IR_W-1:0]          ir_sh_ff, nxt_ir_sh;
    logic [IR_W-1:0]          instr_ff, nxt_instr;
    logic [BSR_LEN-1:0]       bsr_ff, nxt_bsr;
    logic [UPD_W-1:0]         upd_ff, nxt_upd;
    logic                     ctrl_ff, nxt_ctrl;
    logic [ID_W-1:0]          id_sh_ff, nxt_id_sh;
    logic                     byp_ff, nxt_byp;
    logic                     nxt_tdo, nxt_tdo_oe;
    logic [BSR_LEN-1:0]       cap;
    logic                     bsr_sel;
    logic                     ctrl_ld;

    // Pads and core outputs are foreign to the test clock: two flops each.
    // Core reset is brought over the same way, so power-up selects the ID.
    always_ff @(posedge test_clk)
    begin
        rst_meta_ff  <= reset;
        tap_rst_ff   <= rst_meta_ff;
        pad_meta_ff  <= {pad_echo_n_in, pad_echo_in, pad_q_in, pad_in};
        pad_s_ff     <= pad_meta_ff;
        core_meta_ff <= {sram_q_oe, sram_echo_n, sram_echo, sram_q};
        core_s_ff    <= core_meta_ff;
    end

    ssioc_tap_fsm u_fsm (
        .test_clk (test_clk),
        .tap_rst  (tap_rst_ff),
        .tms      (tms),
        .state_ff (tap_st)
    );

    assign bsr_sel = uses_bsr(instr_ff);
    assign ctrl_ld = instr_ff == `SSIOC_I_EXTEST || instr_ff == `SSIOC_I_SAMPLE;

    // Capture sources: pads by default; under sample, internal echo always and internal data only while sram_q_oe is high.
    always_comb
    begin
        cap = {ctrl_ff, pad_s_ff};
        if (instr_ff == `SSIOC_I_SAMPLE)
        begin
            cap[Q_LO+DATA_W +: 2] = core_s_ff[DATA_W +: 2];
            if (core_s_ff[DATA_W+2])
                cap[Q_LO +: DATA_W] = core_s_ff[DATA_W-1:0];
        end
    end

    // Scan register next values, steered by the controller state.
    always_comb
    begin
        nxt_ir_sh = ir_sh_ff;
        nxt_instr = instr_ff;
        nxt_bsr   = bsr_ff;
        nxt_upd   = upd_ff;
        nxt_ctrl  = ctrl_ff;
        nxt_id_sh = id_sh_ff;
        nxt_byp   = byp_ff;
        case (tap_st)
            ssioc_pkg::ST_TLR:    nxt_instr = `SSIOC_I_IDREAD;
            ssioc_pkg::ST_CAP_IR: nxt_ir_sh = `SSIOC_IR_CAPT;
            ssioc_pkg::ST_SH_IR:  nxt_ir_sh = {tdi, ir_sh_ff[IR_W-1:1]};
            ssioc_pkg::ST_UPD_IR: nxt_instr = ir_sh_ff;
            ssioc_pkg::ST_CAP_DR:
            begin
                if (bsr_sel)
                    nxt_bsr = cap;
                nxt_id_sh = ID_CODE;
                nxt_byp   = 1'b0;
            end
            ssioc_pkg::ST_SH_DR:
            begin
                if (bsr_sel)
                    nxt_bsr = {tdi, bsr_ff[BSR_LEN-1:1]};
                nxt_id_sh = {tdi, id_sh_ff[ID_W-1:1]};
                nxt_byp   = tdi;
            end
            ssioc_pkg::ST_UPD_DR:
            begin
                if (bsr_sel)
                    nxt_upd = bsr_ff[CTRL_POS-1:Q_LO];
                if (ctrl_ld)
                    nxt_ctrl = bsr_ff[CTRL_POS];
            end
            default: nxt_bsr = bsr_ff;
        endcase
    end

    // Serial output: reserved codes fall back to the one-bit bypass path.
    always_comb
    begin
        nxt_tdo_oe = tap_st == ssioc_pkg::ST_SH_DR || tap_st == ssioc_pkg::ST_SH_IR;
        if (tap_st == ssioc_pkg::ST_SH_IR)
            nxt_tdo = ir_sh_ff[0];
        else if (bsr_sel)
            nxt_tdo = bsr_ff[0];
        else if (instr_ff == `SSIOC_I_IDREAD)
            nxt_tdo = id_sh_ff[0];
        else
            nxt_tdo = byp_ff;
    end

    always_ff @(posedge test_clk)
    begin
        if (tap_rst_ff)
        begin
            ir_sh_ff <= `SSIOC_IR_CAPT;
            instr_ff <= `SSIOC_I_IDREAD;
            bsr_ff   <= '0;
            upd_ff   <= '0;
            ctrl_ff  <= 1'b0;
            id_sh_ff <= '0;
            byp_ff   <= 1'b0;
        end
        else
        begin
            ir_sh_ff <= nxt_ir_sh;
            instr_ff <= nxt_instr;
            bsr_ff   <= nxt_bsr;
            upd_ff   <= nxt_upd;
            ctrl_ff  <= nxt_ctrl;
            id_sh_ff <= nxt_id_sh;
            byp_ff   <= nxt_byp;
        end
    end

    // Falling-edge launch gives the far end a half period of hold margin.
    always_ff @(negedge test_clk)
    begin
        if (tap_rst_ff)
        begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end
        else
        begin
            tdo    <= nxt_tdo;
            tdo_oe <= nxt_tdo_oe;
        end
    end

    // ---- Core clock domain ----
    localparam ssioc_pkg::ssioc_scan_ctl_t CTL_RST = '{instr: `SSIOC_I_IDREAD, ctrl: 1'b0};
    ssioc_pkg::ssioc_scan_ctl_t ctl_meta_ff, ctl_sy_ff, ctl_hd_ff, ctl_s_ff, nxt_ctl_s;
    logic [UPD_W-1:0]           upd_meta_ff, upd_sy_ff, upd_hd_ff, upd_s_ff, nxt_upd_s;
    ssioc_pkg::ssioc_pin_sel_t  sel;
    logic [1:0]                 nxt_echo, nxt_echo_oe;
    logic [DATA_W-1:0]          nxt_q, nxt_q_oe;

    // A word is taken only once two synchronised samples agree: a bit that
    // resolves late shows at most one mixed word, and that is never acted on.
    // Limitation: updates closer than two core cycles apart may be skipped.
    always_comb
    begin
        nxt_ctl_s = ctl_s_ff;
        nxt_upd_s = upd_s_ff;
        if (ctl_sy_ff == ctl_hd_ff && upd_sy_ff == upd_hd_ff)
        begin
            nxt_ctl_s = ctl_sy_ff;
            nxt_upd_s = upd_sy_ff;
        end
    end

    // Scan state crosses as levels through two flops, then the agreement stage.
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            ctl_meta_ff <= CTL_RST;
            ctl_sy_ff   <= CTL_RST;
            ctl_hd_ff   <= CTL_RST;
            ctl_s_ff    <= CTL_RST;
            upd_meta_ff <= '0;
            upd_sy_ff   <= '0;
            upd_hd_ff   <= '0;
            upd_s_ff    <= '0;
        end
        else
        begin
            ctl_meta_ff <= '{instr: instr_ff, ctrl: ctrl_ff};
            ctl_sy_ff   <= ctl_meta_ff;
            ctl_hd_ff   <= ctl_sy_ff;
            ctl_s_ff    <= nxt_ctl_s;
            upd_meta_ff <= upd_ff;
            upd_sy_ff   <= upd_meta_ff;
            upd_hd_ff   <= upd_sy_ff;
            upd_s_ff    <= nxt_upd_s;
        end
    end

    // Pin drivers chosen from the decoded mode of each pin group.
    always_comb
    begin
        sel = pin_mode(ctl_s_ff.instr, ctl_s_ff.ctrl);
        case (sel.echo)
            ssioc_pkg::PM_UPD:
            begin
                nxt_echo    = upd_s_ff[DATA_W +: 2];
                nxt_echo_oe = 2'h3;
            end
            ssioc_pkg::PM_HIZ:
            begin
                nxt_echo    = 2'h0;
                nxt_echo_oe = 2'h0;
            end
            default:
            begin
                nxt_echo    = {sram_echo_n, sram_echo};
                nxt_echo_oe = 2'h3;
            end
        endcase
        case (sel.q)
            ssioc_pkg::PM_UPD:
            begin
                nxt_q    = upd_s_ff[DATA_W-1:0];
                nxt_q_oe = '1;
            end
            ssioc_pkg::PM_HIZ:
            begin
                nxt_q    = '0;
                nxt_q_oe = '0;
            end
            default:
            begin
                nxt_q    = sram_q;
                nxt_q_oe = {DATA_W{sram_q_oe}};
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            echo_clock_out      <= 1'b0;
            echo_clock_out_n    <= 1'b0;
            echo_clock_out_oe   <= 1'b0;
            echo_clock_out_n_oe <= 1'b0;
            rd_q_out            <= '0;
            rd_q_oe             <= '0;
        end
        else
        begin
            {echo_clock_out_n, echo_clock_out}       <= nxt_echo;
            {echo_clock_out_n_oe, echo_clock_out_oe} <= nxt_echo_oe;
            rd_q_out                                 <= nxt_q;
            rd_q_oe                                  <= nxt_q_oe;
        end
    end

    // ---- Checks ----
    sequence s_cap_pad;
        tap_st == ssioc_pkg::ST_CAP_DR &&
        (instr_ff == `SSIOC_I_EXTEST || instr_ff == `SSIOC_I_SAMPZ);
    endsequence

    sequence s_cap_sample(logic rd);
        tap_st == ssioc_pkg::ST_CAP_DR && instr_ff == `SSIOC_I_SAMPLE &&
        core_s_ff[DATA_W+2] == rd;
    endsequence

    a_ctrl_load_gate: assert property (@(posedge test_clk) disable iff (tap_rst_ff)
        ctrl_ff != $past(ctrl_ff) |-> $past(ctrl_ld && tap_st == ssioc_pkg::ST_UPD_DR))
        else $error("Control bit changed outside update-data.");

    a_pad_capture: assert property (@(posedge test_clk) disable iff (tap_rst_ff)
        s_cap_pad |=> bsr_ff[BSR_LEN-2:0] == $past(pad_s_ff))
        else $error("Pad levels were not captured.");

    a_sample_read_cap: assert property (@(posedge test_clk) disable iff (tap_rst_ff)
        s_cap_sample(1'b1) |=> bsr_ff[Q_LO +: DATA_W+2] == $past(core_s_ff[DATA_W+1:0]))
        else $error("Sample during read did not take internal output.");

    a_sample_idle_cap: assert property (@(posedge test_clk) disable iff (tap_rst_ff)
        s_cap_sample(1'b0) |=> bsr_ff[Q_LO +: DATA_W] == $past(pad_s_ff[Q_LO +: DATA_W]) &&
        bsr_ff[Q_LO+DATA_W +: 2] == $past(core_s_ff[DATA_W +: 2]))
        else $error("Idle sample took the wrong capture source.");

    a_input_capture: assert property (@(posedge test_clk) disable iff (tap_rst_ff)
        s_cap_sample(1'b0) or s_cap_sample(1'b1) |=> bsr_ff[IN_W-1:0] == $past(pad_s_ff[IN_W-1:0])
        ##1 (tap_st != ssioc_pkg::ST_SH_DR || bsr_ff[BSR_LEN-1] == $past(tdi)))
        else $error("Input pins not captured or not shifted.");

    a_reset_idread: assert property (@(posedge test_clk) disable iff (tap_rst_ff)
        tap_st == ssioc_pkg::ST_TLR |=> instr_ff == `SSIOC_I_IDREAD)
        else $error("Reset state did not select identification.");

    a_samplez_float: assert property (@(posedge core_clk) disable iff (reset)
        ctl_s_ff.instr == `SSIOC_I_SAMPZ |=> rd_q_oe == '0 &&
        !echo_clock_out_oe && !echo_clock_out_n_oe)
        else $error("Isolating sample left an output driven.");

    a_extest_echo: assert property (@(posedge core_clk) disable iff (reset)
        ctl_s_ff.instr == `SSIOC_I_EXTEST |=> echo_clock_out_oe && echo_clock_out_n_oe &&
        {echo_clock_out_n, echo_clock_out} == $past(upd_s_ff[DATA_W +: 2]))
        else $error("Echo clocks not driven from update under external test.");

    a_extest_q_ctrl: assert property (@(posedge core_clk) disable iff (reset)
        ctl_s_ff.instr == `SSIOC_I_EXTEST |=> rd_q_oe == {DATA_W{$past(ctl_s_ff.ctrl)}} &&
        (!$past(ctl_s_ff.ctrl) || rd_q_out == $past(upd_s_ff[DATA_W-1:0])))
        else $error("Read data does not follow the control bit.");

    a_normal_pass: assert property (@(posedge core_clk) disable iff (reset)
        ctl_s_ff.instr == `SSIOC_I_IDREAD || ctl_s_ff.instr == `SSIOC_I_SAMPLE ||
        ctl_s_ff.instr == `SSIOC_I_BYPASS |=> rd_q_out == $past(sram_q) &&
        rd_q_oe == {DATA_W{$past(sram_q_oe)}} && echo_clock_out == $past(sram_echo))
        else $error("Normal output not passed through.");
endmodule : ssioc_top
`default_nettype wire

// ### verification/ssioc_tapm.sv
// Behavioural scan test controller that drives the test port.
`timescale 1ns/1ps
`default_nettype none
module ssioc_tapm (
    output logic         test_clk,
    output logic         tms,
    output logic         tdi,
    input  wire logic    tdo,
    input  wire logic    tdo_oe
);
    logic         run;
    logic         oe_ok;
    logic [109:0] sh_out;

    // Idle levels follow the pull-ups on mode select and serial input.
    initial
    begin
        test_clk = 1'b0;
        run = 1'b1;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // The clock parks low between frames so the scan logic sees no stray edges.
    always #24 if (run || test_clk) test_clk = ~test_clk;

    // Signals change just after the edge and hold until the next one.
    task automatic step(input logic m, input logic d);
        tms <= m;
        tdi <= d;
        @(posedge test_clk);
    endtask : step

    // Five high mode bits reach reset from any state, then park in idle.
    task automatic tap_reset();
        run = 1'b1;
        repeat (5) step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        run = 1'b0;
    endtask : tap_reset

    // One instruction or data scan from idle back to idle, bits LSB first.
    task automatic scan(input logic ir, input int n, input logic [109:0] din);
        run = 1'b1;
        step(1'b1, 1'b1);
        if (ir)
            step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        step(1'b0, 1'b1);
        // The output enable must be low before the shift and high through it.
        oe_ok = !tdo_oe;
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i]);
            sh_out[i] = tdo;
            oe_ok = oe_ok & tdo_oe;
        end
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        oe_ok = oe_ok & !tdo_oe;
        run = 1'b0;
    endtask : scan
endmodule : ssioc_tapm
`default_nettype wire

// ### verification/tb.sv
// Testbench for the scan instruction and output pin control block.
`timescale 1ns/1ps
`default_nettype none
`include "ssioc_cfg.svh"
module tb;
    localparam logic [31:0] TB_ID = 32'h0000_5a3c; // Arbitrary identification value.
    localparam logic [2:0]  CODES [5] = '{3'h0, 3'h2, 3'h4, 3'h7, 3'h1};
    logic        core_clk, reset, test_clk, tms, tdi, tdo, tdo_oe, sram_q_oe, sram_echo;
    logic        sram_echo_n, pad_echo_in, pad_echo_n_in, echo_clock_out;
    logic        echo_clock_out_oe, echo_clock_out_n, echo_clock_out_n_oe;
    logic [35:0] sram_q, pad_q_in, rd_q_out, rd_q_oe;
    logic [70:0] pad_in;
    int          miscompares;
    int          check_count;
    wire logic [75:0]  pinv = {echo_clock_out, echo_clock_out_n, echo_clock_out_oe,
                               echo_clock_out_n_oe, rd_q_out, rd_q_oe};
    wire logic [109:0] sh = i_ssioc_tapm.sh_out;

    ssioc_top #(.ID_CODE(TB_ID)) i_ssioc_top (
        .core_clk, .reset, .test_clk, .tms, .tdi, .tdo, .tdo_oe, .sram_q, .sram_q_oe,
        .sram_echo, .sram_echo_n, .pad_in, .pad_q_in, .pad_echo_in, .pad_echo_n_in,
        .echo_clock_out, .echo_clock_out_oe, .echo_clock_out_n, .echo_clock_out_n_oe,
        .rd_q_out, .rd_q_oe
    );
    ssioc_tapm i_ssioc_tapm (.test_clk, .tms, .tdi, .tdo, .tdo_oe);

    // Core clock at 100 ns.
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic chk(input string what, input logic [109:0] exp, input logic [109:0] got);
        check_count++;
        if (exp !== got)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    task automatic ir(input logic [2:0] code);
        i_ssioc_tapm.scan(1'b1, 3, {107'h0, code});
        chk("tdo_oe window", 1'b1, i_ssioc_tapm.oe_ok);
    endtask : ir

    task automatic dr(input logic [109:0] v);
        i_ssioc_tapm.scan(1'b0, 110, v);
        chk("tdo_oe window", 1'b1, i_ssioc_tapm.oe_ok);
    endtask : dr

    // Ten core cycles cover the crossing window with margin before pins are judged.
    task automatic pins(input logic [2:0] ins, input logic c, input logic [109:0] u);
        logic [75:0] e;
        repeat (10) @(posedge core_clk);
        #1;
        e = {sram_echo, sram_echo_n, 2'h3, sram_q, {36{sram_q_oe}}};
        if (ins == `SSIOC_I_SAMPZ)
            e = '0;
        if (ins == `SSIOC_I_EXTEST)
            e = {u[107], u[108], 2'h3, u[106:71] & {36{c}}, {36{c}}};
        chk("output pins", e, pinv);
    endtask : pins

    task automatic t_reset_id();
        i_ssioc_tapm.tap_reset();
        @(posedge core_clk);
        sram_q <= ~sram_q;
        pins(`SSIOC_I_IDREAD, 1'b0, '0);
        dr('0);
        chk("idcode", TB_ID, sh[31:0]);
    endtask : t_reset_id

    // Preload through sample, then walk every defined code with both control values.
    task automatic t_modes();
        logic [109:0] u;
        for (int c = 0; c < 2; c++)
        begin
            u = {c[0], ~c[0], c[0], 36'h9_a5c3_1e7b ^ {36{c[0]}}, 71'h0};
            ir(`SSIOC_I_SAMPLE);
            dr(u);
            foreach (CODES[k])
            begin
                ir(CODES[k]);
                pins(CODES[k], c[0], u);
            end
        end
    endtask : t_modes

    // The control bit must ignore an isolating-sample update but follow external test.
    task automatic t_ctrl_guard();
        logic [109:0] u;
        u = {3'h5, 36'h3_c00f_5aa5, 71'h0};
        ir(`SSIOC_I_SAMPLE);
        dr(u);
        u[109] = 1'b0;
        u[106:71] = 36'h0_ff00_1234;
        ir(`SSIOC_I_SAMPZ);
        dr(u);
        ir(`SSIOC_I_EXTEST);
        pins(`SSIOC_I_EXTEST, 1'b1, u);
        dr(u);
        pins(`SSIOC_I_EXTEST, 1'b0, u);
    endtask : t_ctrl_guard

    task automatic t_capture();
        ir(`SSIOC_I_SAMPLE);
        dr('0);
        chk("sample read", {sram_echo_n, sram_echo, sram_q, pad_in}, sh[108:0]);
        chk("input cells", pad_in, sh[70:0]);
        @(posedge core_clk);
        sram_q_oe <= 1'b0;
        dr('0);
        chk("sample idle", {sram_echo_n, sram_echo, pad_q_in, pad_in}, sh[108:0]);
        @(posedge core_clk);
        sram_q_oe <= 1'b1;
        ir(`SSIOC_I_EXTEST);
        dr('0);
        chk("ext pads", {pad_echo_n_in, pad_echo_in, pad_q_in, pad_in}, sh[108:0]);
        ir(`SSIOC_I_SAMPZ);
        dr('0);
        chk("iso pads", {pad_echo_n_in, pad_echo_in, pad_q_in, pad_in}, sh[108:0]);
    endtask : t_capture

    // Main sequence; the test clock runs through reset so the scan side starts defined.
    initial
    begin
        miscompares = 0;
        check_count = 0;
        reset = 1'b1;
        sram_q = 36'h1_2345_6789;
        sram_q_oe = 1'b1;
        sram_echo = 1'b1;
        sram_echo_n = 1'b0;
        pad_in = 71'h55_0f0f_3c3c_a5a5_9696;
        pad_q_in = 36'hc_3a5f_0e17;
        pad_echo_in = 1'b0;
        pad_echo_n_in = 1'b1;
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        t_reset_id();
        t_modes();
        t_ctrl_guard();
        t_capture();
        t_reset_id();
        close_out();
    end

    // Watchdog against a hung scan.
    initial
    begin
        repeat (40000) @(posedge core_clk);
        miscompares++;
        close_out();
    end
endmodule : tb
`default_nettype wire
